// ### logic/cig_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Enable register 0x60 bits 5..0 channels 0-5
// - Enable register 0xe0 bits 5..0 channels 6-11
// - Bits 7,6 reserved, no interrupt effect
// - Host writes and reads back every enable
// - Enable 0 blocks all channel interrupts
// - Enable 1 passes source-enabled channel interrupts
// - Both enables needed; master alone creates nothing
// - Clearing enable silences whole channel at once
// - Read-only pending flags at 0x61, 0xe1
// - Pending holds until source status read
module cig_top
  import cig_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Parallel register port
  input wire cig_host_req_s host_req,
  output cig_host_rsp_s host_rsp,
  // Per-channel source-level interrupts, already source-enabled
  input wire logic [11:0] src_req,
  // Per-channel pulse: host read that channel's source status
  input wire logic [11:0] src_status_read,
  // Interrupt to host, active high
  output logic host_irq
);

  logic [5:0] en_low;
  logic [5:0] en_high;
  logic [5:0] next_en_low;
  logic [5:0] next_en_high;
  logic [11:0] pend;
  logic [11:0] chan_en;
  logic [11:0] gated;
  logic next_irq;
  cig_host_rsp_s next_rsp;

  function automatic logic [7:0] cig_pack(input logic [5:0] f);
    cig_pack = {CIG_RSVD_READ, f};
  endfunction : cig_pack

  function automatic logic cig_hit(input cig_host_req_s r, input logic [7:0] a);
    cig_hit = (r.addr == a);
  endfunction : cig_hit

  // Enable registers
  always_comb begin
    next_en_low = en_low;
    next_en_high = en_high;
    if (host_req.wr && cig_hit(host_req, CIG_ADDR_EN_LOW)) begin
      next_en_low = host_req.wdata[CIG_FIELD_MSB:CIG_FIELD_LSB];
    end
    if (host_req.wr && cig_hit(host_req, CIG_ADDR_EN_HIGH)) begin
      next_en_high = host_req.wdata[CIG_FIELD_MSB:CIG_FIELD_LSB];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_low <= CIG_EN_RESET;
      en_high <= CIG_EN_RESET;
    end else begin
      en_low <= next_en_low;
      en_high <= next_en_high;
    end
  end

  // Pending flags, one per channel
  for (genvar i = 0; i < CIG_CHANNELS; i++) begin : g_pend
    cig_pend_flag u_flag (
      .sys_clk(sys_clk),
      .rst(rst),
      .src_req(src_req[i]),
      .status_read(src_status_read[i]),
      .pending(pend[i])
    );
  end

  // Gating: master enable only masks, never creates an interrupt
  assign chan_en = {en_high, en_low};
  assign gated = pend & chan_en;

  always_comb begin
    next_irq = |gated;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= next_irq;
    end
  end

  // Read path; unmapped addresses answer zero, writes to pending are ignored
  always_comb begin
    next_rsp.rvalid = host_req.rd;
    next_rsp.rdata = CIG_UNMAPPED_READ;
    if (host_req.rd) begin
      unique case (host_req.addr)
        CIG_ADDR_EN_LOW: next_rsp.rdata = cig_pack(en_low);
        CIG_ADDR_EN_HIGH: next_rsp.rdata = cig_pack(en_high);
        CIG_ADDR_PEND_LOW: next_rsp.rdata = cig_pack(pend[5:0]);
        CIG_ADDR_PEND_HIGH: next_rsp.rdata = cig_pack(pend[11:6]);
        default: next_rsp.rdata = CIG_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_rsp.rvalid <= 1'b0;
      host_rsp.rdata <= CIG_RDATA_RESET;
    end else begin
      host_rsp <= next_rsp;
    end
  end

  // Checks
  sequence s_wr_low;
    host_req.wr && host_req.addr == CIG_ADDR_EN_LOW;
  endsequence

  sequence s_wr_high;
    host_req.wr && host_req.addr == CIG_ADDR_EN_HIGH;
  endsequence

  sequence s_rd_pend_low;
    host_req.rd && host_req.addr == CIG_ADDR_PEND_LOW;
  endsequence

  sequence s_rd_pend_high;
    host_req.rd && host_req.addr == CIG_ADDR_PEND_HIGH;
  endsequence

  // Pending registers are read-only, so writes there must leave enables alone
  sequence s_wr_pend;
    host_req.wr && (host_req.addr == CIG_ADDR_PEND_LOW || host_req.addr == CIG_ADDR_PEND_HIGH);
  endsequence

  property p_en_low_write;
    @(posedge sys_clk) disable iff (rst)
      s_wr_low |=> (en_low == $past(host_req.wdata[5:0]));
  endproperty
  a_en_low_write: assert property (p_en_low_write) else $error("low enable not written");

  property p_en_high_write;
    @(posedge sys_clk) disable iff (rst)
      s_wr_high |=> (en_high == $past(host_req.wdata[5:0]));
  endproperty
  a_en_high_write: assert property (p_en_high_write) else $error("high enable not written");

  property p_rsvd_zero;
    @(posedge sys_clk) disable iff (rst)
      host_rsp.rvalid |-> (host_rsp.rdata[7:6] == 2'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

  property p_readback;
    @(posedge sys_clk) disable iff (rst)
      (host_req.rd && host_req.addr == CIG_ADDR_EN_HIGH && !host_req.wr)
        |=> host_rsp.rvalid && host_rsp.rdata[5:0] == $past(en_high);
  endproperty
  a_readback: assert property (p_readback) else $error("enable readback mismatch");

  property p_readback_low;
    @(posedge sys_clk) disable iff (rst)
      (host_req.rd && host_req.addr == CIG_ADDR_EN_LOW && !host_req.wr)
        |=> host_rsp.rvalid && host_rsp.rdata[5:0] == $past(en_low);
  endproperty
  a_readback_low: assert property (p_readback_low) else $error("low enable readback mismatch");

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (rst)
      !host_req.rd |=> !host_rsp.rvalid && host_rsp.rdata == CIG_UNMAPPED_READ;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read answer outside a read");

  property p_block_off;
    @(posedge sys_clk) disable iff (rst)
      host_irq |-> ($past(pend & chan_en) != 12'h000);
  endproperty
  a_block_off: assert property (p_block_off) else $error("irq from disabled channel");

  property p_pass_on;
    @(posedge sys_clk) disable iff (rst)
      (gated != 12'h000) |=> host_irq;
  endproperty
  a_pass_on: assert property (p_pass_on) else $error("enabled pending did not raise irq");

  property p_master_alone;
    @(posedge sys_clk) disable iff (rst)
      (pend == 12'h000 && src_req == 12'h000) |=> ##1 !host_irq;
  endproperty
  a_master_alone: assert property (p_master_alone) else $error("irq without source");

  property p_clear_all;
    @(posedge sys_clk) disable iff (rst)
      (chan_en == 12'h000) |=> !host_irq;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("irq with all channels off");

  property p_pend_set;
    @(posedge sys_clk) disable iff (rst)
      (src_req != 12'h000) |=> ((pend & $past(src_req)) == $past(src_req));
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending not set");

  property p_pend_hold;
    @(posedge sys_clk) disable iff (rst)
      1'b1 |=> ((pend & ($past(pend) & ~$past(src_status_read))) == ($past(pend) & ~$past(src_status_read)));
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending dropped without status read");

  property p_or_all;
    @(posedge sys_clk) disable iff (rst)
      1'b1 |=> (host_irq == ($past(gated) != 12'h000));
  endproperty
  a_or_all: assert property (p_or_all) else $error("irq not OR of gated pendings");

  property p_pend_read_low;
    @(posedge sys_clk) disable iff (rst)
      s_rd_pend_low |=> host_rsp.rvalid && host_rsp.rdata == {CIG_RSVD_READ, $past(pend[5:0])};
  endproperty
  a_pend_read_low: assert property (p_pend_read_low) else $error("low pending readback mismatch");

  property p_pend_read_high;
    @(posedge sys_clk) disable iff (rst)
      s_rd_pend_high |=> host_rsp.rvalid && host_rsp.rdata == {CIG_RSVD_READ, $past(pend[11:6])};
  endproperty
  a_pend_read_high: assert property (p_pend_read_high) else $error("high pending readback mismatch");

  property p_pend_wr_ignored;
    @(posedge sys_clk) disable iff (rst)
      s_wr_pend |=> (en_low == $past(en_low)) && (en_high == $past(en_high));
  endproperty
  a_pend_wr_ignored: assert property (p_pend_wr_ignored) else $error("write to pending changed enables");

endmodule : cig_top

// ### logic/cig_pkg.sv
package cig_pkg;

  localparam int CIG_CHANNELS = 12;
  localparam int CIG_HALF = 6;

  // Register offsets on the parallel port
  localparam logic [7:0] CIG_ADDR_EN_LOW = 8'h60;
  localparam logic [7:0] CIG_ADDR_PEND_LOW = 8'h61;
  localparam logic [7:0] CIG_ADDR_EN_HIGH = 8'he0;
  localparam logic [7:0] CIG_ADDR_PEND_HIGH = 8'he1;

  // Field layout: channel bits sit at 5..0, bits 7..6 reserved
  localparam int CIG_FIELD_LSB = 0;
  localparam int CIG_FIELD_MSB = 5;
  localparam logic [1:0] CIG_RSVD_READ = 2'h0;

  // Values after reset
  localparam logic [5:0] CIG_EN_RESET = 6'h00;
  localparam logic [11:0] CIG_PEND_RESET = 12'h000;
  localparam logic [7:0] CIG_RDATA_RESET = 8'h00;
  localparam logic [7:0] CIG_UNMAPPED_READ = 8'h00;

  // Read data appears this many cycles after the read strobe
  localparam int CIG_READ_LATENCY = 1;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cig_host_req_s;

  typedef struct packed {
    logic rvalid;
    logic [7:0] rdata;
  } cig_host_rsp_s;

endpackage : cig_pkg

// ### logic/cig_pend_flag.sv
`timescale 1ns/100ps
module cig_pend_flag
  import cig_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Channel events
  input wire logic src_req,
  input wire logic status_read,
  // Flag
  output logic pending
);

  logic next_pending;

  // New request beats a simultaneous clear so no event is lost
  always_comb begin
    next_pending = src_req | (pending & ~status_read);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end

endmodule : cig_pend_flag

// ### dv/cig_host_model.sv
`timescale 1ns/100ps
module cig_host_model
  import cig_pkg::*;
(
  // Bus side
  input wire logic sys_clk,
  output cig_host_req_s host_req,
  input wire cig_host_rsp_s host_rsp
);
  initial host_req = '0;

  // Strobes last exactly one cycle, then the request is cleared
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 host_req = '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    #1 host_req = '0;
  endtask : wr

  // Answer is registered, so it is valid right after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    #1 host_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    #1 host_req = '0;
    d = host_rsp.rdata;
    v = host_rsp.rvalid;
  endtask : rd
endmodule : cig_host_model

// ### dv/channel_interrupt_enable_gating_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module channel_interrupt_enable_gating_tb_top
  import cig_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] src_req = '0;
  logic [11:0] src_status_read = '0;
  logic host_irq;
  cig_host_req_s host_req;
  cig_host_rsp_s host_rsp;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;

  always #50 sys_clk = ~sys_clk;

  cig_top u_dut (.sys_clk(sys_clk), .rst(rst), .host_req(host_req), .host_rsp(host_rsp),
    .src_req(src_req), .src_status_read(src_status_read), .host_irq(host_irq));
  cig_host_model u_host (.sys_clk(sys_clk), .host_req(host_req), .host_rsp(host_rsp));

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK($sformatf("reg %h", a), e, d)
  endtask : rchk

  // One-cycle pulse on the channel event inputs
  task automatic pulse(input logic [11:0] r, input logic [11:0] s);
    @(posedge sys_clk);
    #1 src_req = r;
    src_status_read = s;
    tick();
    src_req = '0;
    src_status_read = '0;
  endtask : pulse

  task automatic t_regs;
    rchk(CIG_ADDR_EN_LOW, 8'h00);
    rchk(CIG_ADDR_EN_HIGH, 8'h00);
    u_host.wr(CIG_ADDR_EN_LOW, 8'hff);
    rchk(CIG_ADDR_EN_LOW, 8'h3f);
    u_host.wr(CIG_ADDR_EN_HIGH, 8'h95);
    rchk(CIG_ADDR_EN_HIGH, 8'h15);
    u_host.wr(CIG_ADDR_EN_LOW, 8'h2a);
    rchk(CIG_ADDR_EN_LOW, 8'h2a);
    u_host.wr(CIG_ADDR_PEND_LOW, 8'hff);
    rchk(CIG_ADDR_PEND_LOW, 8'h00);
    rchk(8'h33, 8'h00);
    tick();
    `CHK("rvalid drop", 1'b0, host_rsp.rvalid)
    `CHK("rdata idle", 8'h00, host_rsp.rdata)
    $display("t_regs done");
  endtask : t_regs

  task automatic t_gate;
    u_host.wr(CIG_ADDR_EN_LOW, 8'h00);
    u_host.wr(CIG_ADDR_EN_HIGH, 8'h3f);
    tick();
    `CHK("irq idle", 1'b0, host_irq)
    pulse(12'h004, 12'h000);
    tick();
    `CHK("irq masked", 1'b0, host_irq)
    rchk(CIG_ADDR_PEND_LOW, 8'h04);
    u_host.wr(CIG_ADDR_EN_LOW, 8'h04);
    tick();
    `CHK("irq on", 1'b1, host_irq)
    rchk(CIG_ADDR_PEND_LOW, 8'h04);
    u_host.wr(CIG_ADDR_EN_LOW, 8'h00);
    tick();
    `CHK("irq off", 1'b0, host_irq)
    pulse(12'h800, 12'h000);
    tick();
    `CHK("irq ch11", 1'b1, host_irq)
    rchk(CIG_ADDR_PEND_HIGH, 8'h20);
    pulse(12'h000, 12'h804);
    rchk(CIG_ADDR_PEND_HIGH, 8'h00);
    rchk(CIG_ADDR_PEND_LOW, 8'h00);
    `CHK("irq clear", 1'b0, host_irq)
    $display("t_gate done");
  endtask : t_gate

  // Two channels at once, set beating clear, then a reset in mid-run
  task automatic t_mix;
    u_host.wr(CIG_ADDR_EN_LOW, 8'h01);
    u_host.wr(CIG_ADDR_EN_HIGH, 8'h01);
    pulse(12'h041, 12'h000);
    tick();
    `CHK("irq two", 1'b1, host_irq)
    pulse(12'h001, 12'h001);
    rchk(CIG_ADDR_PEND_LOW, 8'h01);
    pulse(12'h000, 12'h001);
    rchk(CIG_ADDR_PEND_LOW, 8'h00);
    `CHK("irq ch6 left", 1'b1, host_irq)
    pulse(12'h000, 12'h040);
    tick();
    `CHK("irq none left", 1'b0, host_irq)
    pulse(12'h001, 12'h000);
    tick();
    `CHK("irq pre rst", 1'b1, host_irq)
    @(posedge sys_clk);
    #1 rst = 1'b1;
    tick();
    tick();
    rst = 1'b0;
    `CHK("irq rst", 1'b0, host_irq)
    rchk(CIG_ADDR_EN_LOW, 8'h00);
    rchk(CIG_ADDR_PEND_LOW, 8'h00);
    $display("t_mix done");
  endtask : t_mix

  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // Whole run is well under 300 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_regs();
    t_gate();
    t_mix();
    complete_run();
  end
endmodule : channel_interrupt_enable_gating_tb_top
